// >>> core/clock_reset_ctrl.sv
// Module: deep-sleep clock gating and software reset control with APB registers
//
// Register access over APB was left to the implementer.
`default_nettype none

module clock_reset_ctrl
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Register bus
  input wire gating_pkg::apb_req_type apb_req,
  output var gating_pkg::apb_resp_type apb_resp,
  // Operating state from the power manager
  input wire logic sleep_mode,
  input wire logic deep_sleep_mode,
  // Device capability bits for the soft reset register
  input wire logic [31:0] capability_mask_reg,
  // Unit side
  input wire logic [gating_pkg::NUM_UNITS-1:0] unit_access,
  output logic [gating_pkg::NUM_UNITS-1:0] unit_clk_en,
  output logic [gating_pkg::NUM_UNITS-1:0] unit_fault,
  output logic [gating_pkg::NUM_RESETS-1:0] unit_reset,
  // Interrupt
  output logic irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  gating_pkg::ctrl_state_type s_q; // Registered state
  gating_pkg::ctrl_state_type s_d; // Next state
  logic auto_gate; // Low-power registers in use
  logic [31:0] sel_gate; // Gating register for the present state
  logic [gating_pkg::NUM_UNITS-1:0] sel_units; // Gate bits per unit
  logic [gating_pkg::NUM_RESETS-1:0] reset_bits; // Soft reset bits per unit
  logic any_fault; // Some unit refused an access
  logic setup_phase; // APB setup cycle
  logic write_done; // APB write completes at this edge
  logic addr_hit; // Address maps to a register
  logic [31:0] read_mux; // Read value of the addressed register
  logic [31:0] soft_wdata; // Soft reset write after capability masking
  logic masked_write; // Write tried to set an absent reset bit
  logic [gating_pkg::IRQ_W-1:0] irq_events; // Events this cycle
  logic [gating_pkg::IRQ_W-1:0] irq_clear; // Write-one-to-clear bits

  // ****************************************************************
  // Gating selection
  // ****************************************************************
  assign auto_gate = s_q.clock_config[gating_pkg::AUTO_GATE_POS];

  // Run register unless auto gating is on and a low-power state holds
  always_comb
  begin
    if (!auto_gate)
    begin
      sel_gate = s_q.run_gate;
    end
    else if (s_q.mode == gating_pkg::mode_deep)
    begin
      sel_gate = s_q.deep_gate;
    end
    else if (s_q.mode == gating_pkg::mode_sleep)
    begin
      sel_gate = s_q.sleep_gate;
    end
    else
    begin
      sel_gate = s_q.run_gate;
    end
  end

  // Pick each unit's gate bit and each reset bit
  for (genvar i = 0; i < gating_pkg::NUM_UNITS; i++)
  begin : g_gate
    assign sel_units[i] = sel_gate[gating_pkg::UNIT_GATE_POS[i]];
  end
  for (genvar j = 0; j < gating_pkg::NUM_RESETS; j++)
  begin : g_reset
    assign reset_bits[j] = s_q.soft_reset[gating_pkg::RESET_BIT_POS[j]];
  end

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  assign setup_phase = apb_req.psel & ~apb_req.penable;
  // Writes land only at the completing edge of a mapped access
  assign write_done = apb_req.psel & apb_req.penable & apb_req.pwrite
    & s_q.resp.pready & ~s_q.resp.pslverr;
  // Absent units keep their reset bits clear
  assign soft_wdata = apb_req.pwdata & gating_pkg::SOFT_RESET_WRITE_MASK
    & capability_mask_reg;
  assign masked_write = write_done && (apb_req.paddr == gating_pkg::SOFT_RESET_OFFSET)
    && ((apb_req.pwdata & gating_pkg::SOFT_RESET_WRITE_MASK & ~capability_mask_reg) != '0);
  assign irq_clear = (write_done && (apb_req.paddr == gating_pkg::IRQ_STATUS_OFFSET)) ?
    apb_req.pwdata[gating_pkg::IRQ_W-1:0] : '0;

  // Read value; reserved bits stay zero since they are never stored
  always_comb
  begin
    addr_hit = 1'b1;
    read_mux = gating_pkg::REG_RESET_VALUE;
    case (apb_req.paddr)
      gating_pkg::SOFT_RESET_OFFSET: read_mux = s_q.soft_reset;
      gating_pkg::CLOCK_CONFIG_OFFSET: read_mux = s_q.clock_config;
      gating_pkg::RUN_GATING_OFFSET: read_mux = s_q.run_gate;
      gating_pkg::SLEEP_GATING_OFFSET: read_mux = s_q.sleep_gate;
      gating_pkg::DEEP_SLEEP_OFFSET: read_mux = s_q.deep_gate;
      gating_pkg::IRQ_STATUS_OFFSET: read_mux[gating_pkg::IRQ_W-1:0] = s_q.irq_status;
      gating_pkg::IRQ_MASK_OFFSET: read_mux[gating_pkg::IRQ_W-1:0] = s_q.irq_mask;
      default: addr_hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    s_d = s_q;
    irq_events = '0;
    // Operating state, deep sleep wins over sleep
    if (deep_sleep_mode)
    begin
      s_d.mode = gating_pkg::mode_deep;
    end
    else if (sleep_mode)
    begin
      s_d.mode = gating_pkg::mode_sleep;
    end
    else
    begin
      s_d.mode = gating_pkg::mode_run;
    end
    // Register writes, masked to the writable bits
    if (write_done)
    begin
      case (apb_req.paddr)
        gating_pkg::SOFT_RESET_OFFSET: s_d.soft_reset = soft_wdata;
        gating_pkg::CLOCK_CONFIG_OFFSET:
          s_d.clock_config = apb_req.pwdata & gating_pkg::CLOCK_CONFIG_WRITE_MASK;
        gating_pkg::RUN_GATING_OFFSET:
          s_d.run_gate = apb_req.pwdata & gating_pkg::GATING_WRITE_MASK;
        gating_pkg::SLEEP_GATING_OFFSET:
          s_d.sleep_gate = apb_req.pwdata & gating_pkg::GATING_WRITE_MASK;
        gating_pkg::DEEP_SLEEP_OFFSET:
          s_d.deep_gate = apb_req.pwdata & gating_pkg::GATING_WRITE_MASK;
        gating_pkg::IRQ_MASK_OFFSET:
          s_d.irq_mask = apb_req.pwdata[gating_pkg::IRQ_W-1:0];
        default: s_d.irq_mask = s_q.irq_mask;
      endcase
    end
    // Clock enables follow the selected gate bits
    s_d.clk_en = sel_units;
    // Reset outputs stay asserted while their bit is one
    s_d.unit_reset = reset_bits;
    // Sticky events; a new event beats a clear in the same cycle
    irq_events[gating_pkg::IRQ_FAULT_POS] = any_fault;
    irq_events[gating_pkg::IRQ_MASKED_WRITE_POS] = masked_write;
    s_d.irq_status = (s_q.irq_status & ~irq_clear) | irq_events;
    s_d.irq = |(s_d.irq_status & s_d.irq_mask);
    // Answer in the first access cycle; unmapped addresses error
    s_d.resp.pready = setup_phase;
    s_d.resp.pslverr = setup_phase & ~addr_hit;
    s_d.resp.prdata = setup_phase ? read_mux : '0;
  end

  // State register; every bit clears on reset
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s_q <= gating_pkg::CTRL_RESET_STATE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Fault checker and outputs
  // ****************************************************************
  gated_access_fault u_fault
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .unit_access(unit_access),
    .clk_en(s_q.clk_en),
    .unit_fault(unit_fault),
    .any_fault(any_fault)
  );

  assign apb_resp = s_q.resp;
  assign unit_clk_en = s_q.clk_en;
  assign unit_reset = s_q.unit_reset;
  assign irq = s_q.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  chk_run_gate_used: assert property (
    !auto_gate |=> unit_clk_en[gating_pkg::UNIT_USB] ==
      $past(s_q.run_gate[gating_pkg::USB_GATE_POS])
      && unit_clk_en[7:0] == $past(s_q.run_gate[7:0]))
    else $error("Run gating not applied");

  chk_reset_clears: assert property (disable iff (1'b0)
    reset |=> s_q.deep_gate == '0 && unit_clk_en == '0 && s_q.soft_reset == '0
      && unit_reset == '0 && !irq)
    else $error("State not cleared by reset");

  chk_deep_select: assert property (
    s_q.mode == gating_pkg::mode_deep && auto_gate |=>
      unit_clk_en[gating_pkg::UNIT_DMA] == $past(s_q.deep_gate[gating_pkg::DMA_GATE_POS])
      && unit_clk_en[7:0] == $past(s_q.deep_gate[7:0]))
    else $error("Deep-sleep gating not applied");

  chk_sleep_select: assert property (
    s_q.mode == gating_pkg::mode_sleep && auto_gate |=>
      unit_clk_en[gating_pkg::UNIT_USB] == $past(s_q.sleep_gate[gating_pkg::USB_GATE_POS]))
    else $error("Sleep gating not applied");

  chk_deep_write: assert property (
    write_done && apb_req.paddr == gating_pkg::DEEP_SLEEP_OFFSET |=>
      s_q.deep_gate == $past(apb_req.pwdata & gating_pkg::GATING_WRITE_MASK))
    else $error("Deep-sleep register write wrong");

  chk_reserved_zero: assert property (
    apb_resp.pready && $past(apb_req.paddr == gating_pkg::DEEP_SLEEP_OFFSET) |->
      (apb_resp.prdata & ~gating_pkg::GATING_WRITE_MASK) == '0)
    else $error("Reserved bits read nonzero");

  chk_soft_masked: assert property (
    write_done && apb_req.paddr == gating_pkg::SOFT_RESET_OFFSET |=>
      (s_q.soft_reset & ~$past(capability_mask_reg)) == '0)
    else $error("Absent reset bit was set");

  chk_reset_map: assert property (
    1'b1 |=> unit_reset == {$past(s_q.soft_reset[gating_pkg::WATCHDOG_RESET_POS]),
      $past(s_q.soft_reset[gating_pkg::HIBERNATE_RESET_POS]),
      $past(s_q.soft_reset[gating_pkg::CONVERTER_RESET_POS])})
    else $error("Reset outputs do not follow bits");

  chk_reset_hold: assert property (
    s_q.soft_reset[gating_pkg::WATCHDOG_RESET_POS] [*2] |->
      unit_reset[gating_pkg::RESET_WATCHDOG])
    else $error("Watchdog reset released early");

  chk_fault_sticky: assert property (
    any_fault |=> s_q.irq_status[gating_pkg::IRQ_FAULT_POS])
    else $error("Fault event not recorded");

  cov_deep_auto: cover property (s_q.mode == gating_pkg::mode_deep && auto_gate
    && unit_clk_en[gating_pkg::UNIT_USB]);
  cov_fault: cover property (any_fault ##1 irq);
  cov_masked_write: cover property (masked_write);
  cov_soft_reset: cover property (unit_reset[gating_pkg::RESET_WATCHDOG]);

endmodule // clock_reset_ctrl

`default_nettype wire

// >>> core/gated_access_fault.sv
// Module: flags accesses that reach a unit whose clock is gated off
`default_nettype none

module gated_access_fault
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Access strobes and present clock enables
  input wire logic [gating_pkg::NUM_UNITS-1:0] unit_access,
  input wire logic [gating_pkg::NUM_UNITS-1:0] clk_en,
  // Fault answers
  output logic [gating_pkg::NUM_UNITS-1:0] unit_fault,
  output logic any_fault
);

  // ****************************************************************
  // State
  // ****************************************************************
  gating_pkg::fault_state_type s_q; // Registered faults
  gating_pkg::fault_state_type s_d; // Next faults
  logic [gating_pkg::NUM_UNITS-1:0] hit; // Access to a stopped unit

  // One checker per unit
  for (genvar i = 0; i < gating_pkg::NUM_UNITS; i++)
  begin : g_unit
    assign hit[i] = unit_access[i] & ~clk_en[i];
  end

  // Next state: a one-cycle fault per refused access
  always_comb
  begin
    s_d = s_q;
    s_d.fault = hit;
    s_d.any = |hit;
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s_q <= gating_pkg::FAULT_RESET_STATE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign unit_fault = s_q.fault;
  assign any_fault = s_q.any;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_fault_gated_unit: assert property (@(posedge ref_clk) disable iff (reset)
    |(unit_access & ~clk_en) |=> (unit_fault == $past(unit_access & ~clk_en)) && any_fault)
    else $error("Access to a gated unit did not fault");

  chk_open_no_fault: assert property (@(posedge ref_clk) disable iff (reset)
    (unit_access & ~clk_en) == '0 |=> !any_fault)
    else $error("Access to a clocked unit faulted");

endmodule // gated_access_fault

`default_nettype wire

// >>> core/gating_pkg.sv
// Package: constants, register map and types of the deep-sleep gating and soft reset block
`default_nettype none

package gating_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned NUM_UNITS = 10;
  localparam int unsigned NUM_RESETS = 3;
  localparam int unsigned IRQ_W = 2;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [11:0] SOFT_RESET_OFFSET = 12'h040;
  localparam logic [11:0] CLOCK_CONFIG_OFFSET = 12'h060;
  localparam logic [11:0] RUN_GATING_OFFSET = 12'h108;
  localparam logic [11:0] SLEEP_GATING_OFFSET = 12'h118;
  localparam logic [11:0] DEEP_SLEEP_OFFSET = 12'h128;
  localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h150;
  localparam logic [11:0] IRQ_MASK_OFFSET = 12'h154;

  // ****************************************************************
  // Writable bits and reset values
  // ****************************************************************
  localparam logic [31:0] GATING_WRITE_MASK = 32'h0001_20FF;
  localparam logic [31:0] SOFT_RESET_WRITE_MASK = 32'h0001_0048;
  localparam logic [31:0] CLOCK_CONFIG_WRITE_MASK = 32'h0000_0001;
  localparam logic [31:0] REG_RESET_VALUE = 32'h0000_0000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned AUTO_GATE_POS = 0;
  localparam int unsigned USB_GATE_POS = 16;
  localparam int unsigned DMA_GATE_POS = 13;
  localparam int unsigned PORT_H_GATE_POS = 7;
  localparam int unsigned CONVERTER_RESET_POS = 16;
  localparam int unsigned HIBERNATE_RESET_POS = 6;
  localparam int unsigned WATCHDOG_RESET_POS = 3;
  localparam int unsigned IRQ_FAULT_POS = 0;
  localparam int unsigned IRQ_MASKED_WRITE_POS = 1;

  // Unit index to gate bit: ports A..H, then DMA, then USB
  localparam int unsigned UNIT_DMA = 8;
  localparam int unsigned UNIT_USB = 9;
  localparam int unsigned UNIT_GATE_POS [NUM_UNITS] =
    '{0, 1, 2, 3, 4, 5, 6, PORT_H_GATE_POS, DMA_GATE_POS, USB_GATE_POS};
  // Reset output index to soft reset bit: converter, hibernate, watchdog
  localparam int unsigned RESET_WATCHDOG = 2;
  localparam int unsigned RESET_BIT_POS [NUM_RESETS] =
    '{CONVERTER_RESET_POS, HIBERNATE_RESET_POS, WATCHDOG_RESET_POS};

  // ****************************************************************
  // Types
  // ****************************************************************
  // Operating state of the device
  typedef enum logic [1:0] {mode_run, mode_sleep, mode_deep} power_mode_type;

  // APB request from the master
  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_type;

  // APB answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_resp_type;

  // All state of the control block
  typedef struct packed {
    logic [31:0] run_gate;
    logic [31:0] sleep_gate;
    logic [31:0] deep_gate;
    logic [31:0] clock_config;
    logic [31:0] soft_reset;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    power_mode_type mode;
    logic [NUM_UNITS-1:0] clk_en;
    logic [NUM_RESETS-1:0] unit_reset;
    logic irq;
    apb_resp_type resp;
  } ctrl_state_type;

  // All state of the fault checker
  typedef struct packed {
    logic [NUM_UNITS-1:0] fault;
    logic any;
  } fault_state_type;

  localparam ctrl_state_type CTRL_RESET_STATE = '0;
  localparam fault_state_type FAULT_RESET_STATE = '0;

endpackage

`default_nettype wire

// >>> testbench/deep_sleep_gating_and_soft_reset_tb_top.sv
// Testbench: register, gating, fault, interrupt and soft reset checks of the control block
`default_nettype none

module deep_sleep_gating_and_soft_reset_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic ref_clk = 1'b0; // Bench clock
  logic reset = 1'b1; // Synchronous reset
  gating_pkg::apb_req_type req = '0; // Bus request
  gating_pkg::apb_resp_type resp; // Bus answer
  logic sleep_mode = 1'b0; // Sleep state input
  logic deep_sleep_mode = 1'b0; // Deep sleep state input
  logic [31:0] cap = 32'hFFFF_FFFF; // Capability bits
  logic [9:0] access = 10'h000; // Access strobes
  logic [9:0] clk_en; // Unit clock enables
  logic [9:0] fault; // Fault pulses
  logic [2:0] unit_reset; // Unit resets
  logic irq; // Interrupt level
  int num_errors = 0; // Mismatch count
  int num_checks = 0; // Comparison count
  logic [31:0] rd; // Last read data
  logic [31:0] err; // Last error answer

  // Register table rows: write, then read back
  typedef struct {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] err;
  } row_type;
  row_type rows [5] = '{
    '{gating_pkg::DEEP_SLEEP_OFFSET, 32'hFFFF_FFFF, 32'h0001_20FF, 32'h0000_0000},
    '{gating_pkg::RUN_GATING_OFFSET, 32'hFFFF_FFFF, 32'h0001_20FF, 32'h0000_0000},
    '{gating_pkg::SLEEP_GATING_OFFSET, 32'h0000_0055, 32'h0000_0055, 32'h0000_0000},
    '{gating_pkg::SOFT_RESET_OFFSET, 32'hFFFF_FFFF, 32'h0001_0048, 32'h0000_0000},
    '{12'h0FC, 32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0001}};
  // Every mapped register, for the reset value sweep
  logic [11:0] regs [7] = '{gating_pkg::SOFT_RESET_OFFSET, gating_pkg::CLOCK_CONFIG_OFFSET,
    gating_pkg::RUN_GATING_OFFSET, gating_pkg::SLEEP_GATING_OFFSET,
    gating_pkg::DEEP_SLEEP_OFFSET, gating_pkg::IRQ_STATUS_OFFSET, gating_pkg::IRQ_MASK_OFFSET};

  // ****************************************************************
  // Design under test
  // ****************************************************************
  clock_reset_ctrl clock_reset_ctrl_i
  (
    .ref_clk(ref_clk),
    .reset(reset),
    .apb_req(req),
    .apb_resp(resp),
    .sleep_mode(sleep_mode),
    .deep_sleep_mode(deep_sleep_mode),
    .capability_mask_reg(cap),
    .unit_access(access),
    .unit_clk_en(clk_en),
    .unit_fault(fault),
    .unit_reset(unit_reset),
    .irq(irq)
  );

  // Clock of 10 ns period
  always #5 ref_clk = ~ref_clk;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Compare a seen value with the expected one
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Wait a fixed number of edges
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One bus transfer: setup, then access until pready is sampled high
  task automatic apb(input logic [11:0] addr, input logic wr, input logic [31:0] wdata);
    int n;
    @(posedge ref_clk);
    req.paddr <= addr;
    req.pwrite <= wr;
    req.pwdata <= wdata;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    @(posedge ref_clk);
    req.penable <= 1'b1;
    n = 0;
    // Bounded wait for the answer
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (resp.pready !== 1'b1 && n < 20);
    // Answer taken at the edge where pready is sampled high
    rd = resp.prdata;
    err = {31'h0000_0000, resp.pslverr};
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    // A missing answer counts as a mismatch and ends the run
    if (resp.pready !== 1'b1)
    begin
      check({31'h0000_0000, resp.pready}, 32'h0000_0001);
      report_and_stop();
    end
  endtask

  // Register write and read
  task automatic wr(input logic [11:0] addr, input logic [31:0] data);
    apb(addr, 1'b1, data);
  endtask
  task automatic rdreg(input logic [11:0] addr);
    apb(addr, 1'b0, 32'h0000_0000);
  endtask

  // Access strobe for one cycle, then look at the fault pulse
  task automatic pulse(input logic [9:0] bits, input logic [9:0] exp);
    @(posedge ref_clk);
    access <= bits;
    @(posedge ref_clk);
    access <= 10'h000;
    @(posedge ref_clk);
    check({22'h00_0000, fault}, {22'h00_0000, exp});
  endtask

  // Reset for 6 cycles, then clock enables, unit resets and all registers read zero
  task automatic reset_and_sweep();
    @(posedge ref_clk);
    reset <= 1'b1;
    cycles(6);
    reset <= 1'b0;
    cycles(1);
    check({22'h00_0000, clk_en}, 32'h0000_0000);
    check({29'h0000_0000, unit_reset}, 32'h0000_0000);
    foreach (regs[i])
    begin
      rdreg(regs[i]);
      check(rd, 32'h0000_0000);
    end
    $display("test reset done");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    reset_and_sweep();
    // Table rows: reserved bits and unmapped address error
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata);
      check(err, rows[i].err);
      rdreg(rows[i].addr);
      check(rd, rows[i].rdata);
      check(err, rows[i].err);
    end
    $display("test register table done");
    // Selection of the gating register by state
    wr(gating_pkg::RUN_GATING_OFFSET, 32'h0000_0001);
    wr(gating_pkg::SLEEP_GATING_OFFSET, 32'h0000_0002);
    wr(gating_pkg::DEEP_SLEEP_OFFSET, 32'h0001_2080);
    deep_sleep_mode <= 1'b1;
    cycles(3);
    check({22'h00_0000, clk_en}, 32'h0000_0001);
    wr(gating_pkg::CLOCK_CONFIG_OFFSET, 32'h0000_0001);
    cycles(2);
    check({22'h00_0000, clk_en}, 32'h0000_0380);
    deep_sleep_mode <= 1'b0;
    sleep_mode <= 1'b1;
    cycles(3);
    check({22'h00_0000, clk_en}, 32'h0000_0002);
    sleep_mode <= 1'b0;
    cycles(3);
    check({22'h00_0000, clk_en}, 32'h0000_0001);
    $display("test gating done");
    // Faults on gated units, interrupt raise and clear
    wr(gating_pkg::IRQ_MASK_OFFSET, 32'h0000_0003);
    pulse(10'h008, 10'h008);
    cycles(3);
    check({31'h0000_0000, irq}, 32'h0000_0001);
    rdreg(gating_pkg::IRQ_STATUS_OFFSET);
    check(rd, 32'h0000_0001);
    pulse(10'h001, 10'h000);
    wr(gating_pkg::IRQ_STATUS_OFFSET, 32'h0000_0001);
    cycles(2);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    $display("test fault done");
    // Capability masking and hold in reset
    cap <= 32'h0000_0008;
    wr(gating_pkg::SOFT_RESET_OFFSET, 32'h0001_0048);
    cycles(2);
    check({29'h0000_0000, unit_reset}, 32'h0000_0004);
    rdreg(gating_pkg::SOFT_RESET_OFFSET);
    check(rd, 32'h0000_0008);
    rdreg(gating_pkg::IRQ_STATUS_OFFSET);
    check(rd, 32'h0000_0002);
    wr(gating_pkg::SOFT_RESET_OFFSET, 32'h0000_0000);
    cycles(2);
    check({29'h0000_0000, unit_reset}, 32'h0000_0000);
    wr(gating_pkg::IRQ_STATUS_OFFSET, 32'h0000_0002);
    $display("test soft reset done");
    // Masked interrupt stays low
    wr(gating_pkg::IRQ_MASK_OFFSET, 32'h0000_0000);
    pulse(10'h200, 10'h200);
    cycles(3);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    $display("test mask done");
    // Second reset in mid-run
    reset_and_sweep();
    report_and_stop();
  end

endmodule // deep_sleep_gating_and_soft_reset_tb_top

`default_nettype wire
